// ==== logic/afz_pkg.sv ====
package afz_pkg;
  localparam int CLK_MHZ     = 100;
  localparam int SEC_MS      = 1000;
  localparam int SEC_CYC     = SEC_MS * 1000 * CLK_MHZ;
  localparam int CHAIN_US    = 500;
  localparam int CHAIN_CYC   = CHAIN_US * CLK_MHZ;
  localparam int BLINK_MS    = 250;
  localparam int BLINK_CYC   = BLINK_MS * 1000 * CLK_MHZ;
  localparam int COOL_MS     = 10000;
  localparam int COOL_CYC    = COOL_MS * 1000 * CLK_MHZ;
  localparam int PULSE_MS    = 100;
  localparam int CBF_MS      = 60;
  localparam logic [31:0] PULSE_DEF = 32'(PULSE_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] CBF_DEF   = 32'(CBF_MS * 1000 * CLK_MHZ);
  // light in steps of 100 lux
  localparam logic [7:0] THRESH_DEF = 8'h64;
  localparam logic [7:0] THRESH_MAX = 8'hFA;
  localparam logic [7:0] MAP_DEF    = 8'hA5;
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_THRESH = 8'h04;
  localparam logic [7:0] A_PULSE  = 8'h08;
  localparam logic [7:0] A_CBFTO  = 8'h0C;
  localparam logic [7:0] A_MAP    = 8'h10;
  localparam logic [7:0] A_CMD    = 8'h14;
  localparam logic [7:0] A_STAT   = 8'h18;
  localparam int CTRL_MODE = 0;
  localparam int CTRL_POL  = 8;
  localparam int CMD_RST   = 0;
  localparam int ST_HEALTH = 0;
  localparam int ST_FAULT  = 1;
  localparam int ST_CBF    = 2;
  localparam int ST_COIL   = 4;
  localparam int ST_ERR    = 8;
  localparam int ST_SENS   = 16;
  typedef enum logic {CS_IDLE = 1'b0, CS_ON = 1'b1} afz_coil_t;
endpackage

// ==== logic/afz_trip_zone.sv ====
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module afz_trip_zone #(
  parameter int NZ      = 2,
  parameter int NS      = 4,
  parameter int NERR    = 2,
  parameter int SECC    = afz_pkg::SEC_CYC,
  parameter int CHAINC  = afz_pkg::CHAIN_CYC,
  parameter int BLINKC  = afz_pkg::BLINK_CYC,
  parameter int COOLC   = afz_pkg::COOL_CYC
) (
  input  wire logic            clock,
  input  wire logic            srst,
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [31:0]     rdata,
  input  wire logic [NS*8-1:0] sensorLevel,
  input  wire logic [NZ-1:0]   inhibitPin,
  input  wire logic [NZ-1:0]   firePin,
  input  wire logic [NZ-1:0]   cbOnPin,
  input  wire logic            resetPin,
  input  wire logic [NZ-1:0]   coilVoltOk,
  input  wire logic [NERR-1:0] errIn,
  output logic                 healthRelay,
  output logic                 faultRelay,
  output logic                 cbFailOut,
  output logic      [NZ-1:0]   coilOut,
  output logic      [NZ-1:0]   chainOut,
  output logic      [NZ-1:0]   inhibitLed,
  output logic      [NZ-1:0]   fireLed,
  output logic      [NZ-1:0]   cbOnLed,
  output logic      [NZ-1:0]   coilRedLed,
  output logic      [NZ-1:0]   coilFlash,
  output logic      [NS-1:0]   sensorLed
);
  import afz_pkg::*;
  localparam int MW = NS * NZ;
  localparam int EW = NERR + NZ;

  logic [NZ-1:0]   inhS1, inhS2, fireS1, fireS2, cbS1, cbS2;
  logic            rstS1, rstS2;
  logic [NZ-1:0]   mode_reg, pol_reg;
  logic [7:0]      thresh_reg;
  logic [31:0]     pulse_reg, cbfTo_reg;
  logic [MW-1:0]   map_reg;
  logic            swRst_reg;
  logic [NZ-1:0]   inhAct, fireAct, cbAct, zoneLight;
  logic [NZ-1:0]   tripReq, tripEvt, tripReqPrev_reg, cbfExp;
  logic [NS-1:0]   lightHit;
  logic            rstAct, busy, clearTrip, anyEvt;
  afz_coil_t       coilSt_reg [NZ];
  logic [31:0]     coilCnt_reg [NZ];
  logic [1:0]      heat_reg [NZ];
  logic [31:0]     cool_reg [NZ];
  logic [31:0]     cbfCnt_reg [NZ];
  logic [NZ-1:0]   cbfRun_reg;
  logic [31:0]     chain_reg [NZ];
  logic [NZ-1:0]   coilFlag_reg, inhLat_reg, fireLat_reg, cbLat_reg;
  logic [NS-1:0]   sensFlag_reg;
  logic            faultLatch_reg, cbfFlag_reg;
  logic [31:0]     faultDrop_reg, hp_reg, cbfPulse_reg, blink_reg;
  logic            blinkOn_reg;
  logic [EW-1:0]   errVec, errPrev_reg;
  logic [NZ-1:0]   coilMissing;
  logic            newErr;
  logic [31:0]     stat;

  // two flops each; the first is read by nothing else
  always_ff @(posedge clock) begin
    inhS1  <= inhibitPin;
    inhS2  <= inhS1;
    fireS1 <= firePin;
    fireS2 <= fireS1;
    cbS1   <= cbOnPin;
    cbS2   <= cbS1;
    rstS1  <= resetPin;
    rstS2  <= rstS1;
  end

  always_comb begin
    inhAct  = ~inhS2;
    fireAct = ~fireS2;
    cbAct   = cbS2 ^ pol_reg;
    rstAct  = ~rstS2 | swRst_reg;
  end

  always_comb begin
    zoneLight = '0;
    for (int s = 0; s < NS; s++) begin
      lightHit[s] = sensorLevel[s*8 +: 8] > thresh_reg;
      for (int z = 0; z < NZ; z++) begin
        if (map_reg[s*NZ+z] && lightHit[s]) begin
          zoneLight[z] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    tripReq = (zoneLight | fireAct) & ~inhAct;
    tripEvt = tripReq & ~tripReqPrev_reg;
    anyEvt  = |tripEvt;
    busy    = |cbfRun_reg;
    for (int z = 0; z < NZ; z++) begin
      busy      = busy | (coilSt_reg[z] == CS_ON);
      cbfExp[z] = cbfRun_reg[z] && (cbfCnt_reg[z] == 32'h0000_0000);
    end
    // a short reset during a trip is ignored; a held one lands afterwards
    clearTrip = rstAct & ~busy;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      tripReqPrev_reg <= '0;
    end else begin
      tripReqPrev_reg <= tripReq;
    end
  end

  // actuator pulse, thermal derating and breaker-failure timer
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int z = 0; z < NZ; z++) begin
        coilSt_reg[z]  <= CS_IDLE;
        coilCnt_reg[z] <= '0;
        heat_reg[z]    <= '0;
        cool_reg[z]    <= '0;
        cbfCnt_reg[z]  <= '0;
      end
      cbfRun_reg <= '0;
    end else begin
      for (int z = 0; z < NZ; z++) begin
        if (tripEvt[z]) begin
          coilSt_reg[z] <= CS_ON;
          if ((pulse_reg >> heat_reg[z]) == 32'h0000_0000) begin
            coilCnt_reg[z] <= 32'h0000_0001;
          end else begin
            coilCnt_reg[z] <= pulse_reg >> heat_reg[z];
          end
          if (heat_reg[z] != 2'h3) begin
            heat_reg[z] <= heat_reg[z] + 2'h1;
          end
          cool_reg[z]   <= 32'(COOLC);
          cbfCnt_reg[z] <= cbfTo_reg;
          cbfRun_reg[z] <= 1'b1;
        end else begin
          unique case (coilSt_reg[z])
            CS_IDLE: begin
              coilCnt_reg[z] <= '0;
            end
            CS_ON: begin
              if (coilCnt_reg[z] <= 32'h0000_0001) begin
                coilSt_reg[z] <= CS_IDLE;
              end else begin
                coilCnt_reg[z] <= coilCnt_reg[z] - 32'h0000_0001;
              end
            end
          endcase
          if (cool_reg[z] == 32'h0000_0000) begin
            heat_reg[z] <= '0;
          end else begin
            cool_reg[z] <= cool_reg[z] - 32'h0000_0001;
          end
          if (cbfExp[z]) begin
            cbfRun_reg[z] <= 1'b0;
          end else if (cbfRun_reg[z]) begin
            cbfCnt_reg[z] <= cbfCnt_reg[z] - 32'h0000_0001;
          end
        end
      end
    end
  end

  // chaining pulses and actuator drive
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int z = 0; z < NZ; z++) begin
        chain_reg[z] <= '0;
      end
      chainOut <= '0;
      coilOut  <= '0;
    end else begin
      for (int z = 0; z < NZ; z++) begin
        if (tripEvt[z]) begin
          chain_reg[z] <= 32'(CHAINC);
        end else if (chain_reg[z] != 32'h0000_0000) begin
          chain_reg[z] <= chain_reg[z] - 32'h0000_0001;
        end
        chainOut[z] <= chain_reg[z] != 32'h0000_0000;
        // undervoltage coil holds the breaker while idle
        coilOut[z] <= (coilSt_reg[z] == CS_ON) ^ mode_reg[z];
      end
    end
  end

  // breaker failure: feedback sampled once at expiry
  always_ff @(posedge clock) begin
    if (srst) begin
      cbfPulse_reg <= '0;
      cbFailOut    <= 1'b0;
    end else begin
      if (|(cbfExp & cbAct)) begin
        cbfPulse_reg <= 32'(CHAINC);
      end else if (cbfPulse_reg != 32'h0000_0000) begin
        cbfPulse_reg <= cbfPulse_reg - 32'h0000_0001;
      end
      cbFailOut <= cbfPulse_reg != 32'h0000_0000;
    end
  end

  // trip flags and latched indicators; a set beats a clear
  always_ff @(posedge clock) begin
    if (srst) begin
      coilFlag_reg <= '0;
      inhLat_reg   <= '0;
      fireLat_reg  <= '0;
      cbLat_reg    <= '0;
      sensFlag_reg <= '0;
      cbfFlag_reg  <= 1'b0;
    end else begin
      coilFlag_reg <= tripEvt | (coilFlag_reg & {NZ{~clearTrip}});
      inhLat_reg   <= (inhAct & (zoneLight | fireAct))
                    | (inhLat_reg & {NZ{~clearTrip}});
      fireLat_reg  <= (tripEvt & fireAct)
                    | (fireLat_reg & {NZ{~clearTrip}});
      cbLat_reg    <= (cbfExp & cbAct)
                    | (cbLat_reg & {NZ{~clearTrip}});
      sensFlag_reg <= lightHit | (sensFlag_reg & {NS{~clearTrip}});
      cbfFlag_reg  <= (|(cbfExp & cbAct)) | (cbfFlag_reg & ~clearTrip);
    end
  end

  // fault-flag relay
  always_ff @(posedge clock) begin
    if (srst) begin
      faultLatch_reg <= 1'b0;
      faultDrop_reg  <= '0;
      faultRelay     <= 1'b0;
    end else begin
      faultLatch_reg <= anyEvt | (faultLatch_reg & ~clearTrip);
      if (anyEvt && faultLatch_reg) begin
        faultDrop_reg <= 32'(SECC);
      end else if (faultDrop_reg != 32'h0000_0000) begin
        faultDrop_reg <= faultDrop_reg - 32'h0000_0001;
      end
      faultRelay <= faultLatch_reg && (faultDrop_reg == 32'h0000_0000);
    end
  end

  // health: level errors only, the reset input cannot touch them
  always_comb begin
    coilMissing = ~coilVoltOk & ~mode_reg;
    errVec      = {errIn, coilMissing};
    newErr      = (|(errVec & ~errPrev_reg)) && (|errPrev_reg);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      errPrev_reg <= '0;
      hp_reg      <= '0;
      healthRelay <= 1'b0;
    end else begin
      errPrev_reg <= errVec;
      if (newErr) begin
        hp_reg <= 32'(SECC);
      end else if (hp_reg != 32'h0000_0000) begin
        hp_reg <= hp_reg - 32'h0000_0001;
      end
      healthRelay <= ~(|errVec) | (hp_reg != 32'h0000_0000);
    end
  end

  // indicators
  always_ff @(posedge clock) begin
    if (srst) begin
      blink_reg   <= '0;
      blinkOn_reg <= 1'b0;
      inhibitLed  <= '0;
      fireLed     <= '0;
      cbOnLed     <= '0;
      coilRedLed  <= '0;
      coilFlash   <= '0;
      sensorLed   <= '0;
    end else begin
      if (blink_reg == 32'h0000_0000) begin
        blink_reg   <= 32'(BLINKC);
        blinkOn_reg <= ~blinkOn_reg;
      end else begin
        blink_reg <= blink_reg - 32'h0000_0001;
      end
      inhibitLed <= inhAct | inhLat_reg;
      fireLed    <= fireAct | fireLat_reg;
      cbOnLed    <= cbAct | cbLat_reg;
      coilRedLed <= coilFlag_reg;
      coilFlash  <= coilMissing & {NZ{blinkOn_reg}};
      sensorLed  <= sensFlag_reg;
    end
  end

  // register port
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg   <= '0;
      pol_reg    <= '0;
      thresh_reg <= THRESH_DEF;
      pulse_reg  <= PULSE_DEF;
      cbfTo_reg  <= CBF_DEF;
      map_reg    <= MW'(MAP_DEF);
      swRst_reg  <= 1'b0;
    end else begin
      swRst_reg <= wr && (addr == A_CMD) && wdata[CMD_RST];
      if (wr) begin
        unique case (addr)
          A_CTRL: begin
            mode_reg <= wdata[CTRL_MODE +: NZ];
            pol_reg  <= wdata[CTRL_POL +: NZ];
          end
          A_THRESH: begin
            if (wdata[7:0] > THRESH_MAX) begin
              thresh_reg <= THRESH_MAX;
            end else begin
              thresh_reg <= wdata[7:0];
            end
          end
          A_PULSE: begin
            pulse_reg <= wdata;
          end
          A_CBFTO: begin
            cbfTo_reg <= wdata;
          end
          A_MAP: begin
            map_reg <= wdata[MW-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    stat = '0;
    stat[ST_HEALTH] = healthRelay;
    stat[ST_FAULT]  = faultLatch_reg;
    stat[ST_CBF]    = cbfFlag_reg;
    stat[ST_COIL +: NZ]  = coilFlag_reg;
    stat[ST_ERR +: EW]   = errVec;
    stat[ST_SENS +: NS]  = sensFlag_reg;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        A_CTRL:   rdata <= 32'(mode_reg) | (32'(pol_reg) << CTRL_POL);
        A_THRESH: rdata <= 32'(thresh_reg);
        A_PULSE:  rdata <= pulse_reg;
        A_CBFTO:  rdata <= cbfTo_reg;
        A_MAP:    rdata <= 32'(map_reg);
        A_STAT:   rdata <= stat;
        default:  rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  AST_HEALTH_ERR: assert property (
    (|errVec && hp_reg == 32'h0000_0000) |=> !healthRelay)
    else $error("health relay on with error");
  AST_HEALTH_PULSE: assert property (
    newErr |=> ##1 healthRelay[*8])
    else $error("no extra-error pulse");
  AST_FAULT_SET: assert property (
    (anyEvt && !faultLatch_reg) |=> ##1 faultRelay)
    else $error("fault relay not set");
  AST_REALARM: assert property (
    (anyEvt && faultLatch_reg) |=> ##1 (!faultRelay)[*8])
    else $error("no re-alarm drop");
  AST_CLEAR: assert property (
    (clearTrip && !anyEvt) |=> !faultLatch_reg && coilFlag_reg == '0)
    else $error("trip state kept after reset");
  AST_SUPPRESS: assert property (
    (inhAct[NZ-1] && coilSt_reg[NZ-1] == CS_IDLE) |=> coilSt_reg[NZ-1] == CS_IDLE)
    else $error("suppressed zone pulsed");
  AST_FIRE: assert property (
    ($fell(firePin[0]) && inhibitPin[0] && $stable(inhibitPin[0])
      && !tripReqPrev_reg[0]) |-> ##[1:5] coilSt_reg[0] == CS_ON)
    else $error("remote fire too slow");
  AST_CHAIN: assert property (
    tripEvt[0] |=> ##1 chainOut[0])
    else $error("no chaining pulse");
  AST_CBF: assert property (
    (cbfExp[0] && cbAct[0]) |=> ##1 cbFailOut)
    else $error("breaker failure not pulsed");
  AST_THRESH: assert property (
    (wr && addr == A_THRESH && wdata[7:0] > THRESH_MAX) |=> thresh_reg == THRESH_MAX)
    else $error("threshold not clamped");
endmodule

// ==== tb/afz_breaker_model.sv ====
`timescale 1ns/10ps
module afz_breaker_model #(
  parameter int NZ    = 2,
  parameter int OPENC = 5
) (
  input  wire logic          clock,
  input  wire logic [NZ-1:0] coilOut,
  input  wire logic [NZ-1:0] uvMode,
  input  wire logic [NZ-1:0] stuck,
  input  wire logic [NZ-1:0] reclose,
  input  wire logic [NZ-1:0] supply,
  output logic      [NZ-1:0] cbOnPin,
  output logic      [NZ-1:0] coilVoltOk
);
  int            cnt [NZ];
  logic [NZ-1:0] closed = '1;
  // closed contact leaves the terminal open, so the line reads high
  assign cbOnPin    = closed;
  assign coilVoltOk = supply;
  always @(posedge clock) begin
    for (int z = 0; z < NZ; z++) begin
      if (reclose[z]) begin
        closed[z] <= 1'b1;
        cnt[z]    <= 0;
      end else if ((coilOut[z] ^ uvMode[z]) && !stuck[z]) begin
        cnt[z] <= cnt[z] + 1;
        // mechanism needs a few cycles of drive before it opens
        if (cnt[z] >= OPENC) closed[z] <= 1'b0;
      end else begin
        cnt[z] <= 0;
      end
    end
  end
endmodule

// ==== tb/arc_flash_trip_zone_logic_tb.sv ====
`timescale 1ns/10ps
module arc_flash_trip_zone_logic_tb;
  import afz_pkg::*;
  localparam int SECC   = 20;
  localparam int CHAINC = 10;
  localparam int PULSE  = 40;
  localparam int CBFT   = 60;
  logic        clock = 0, srst = 1, wr = 0, rd = 0, resetPin = 1;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, rv;
  logic [31:0] sensorLevel = '0;
  logic [1:0]  inhibitPin = '1, firePin = '1, errIn = '0, stuck = '0;
  logic [1:0]  reclose = '0, supply = '1, uvMode = '0;
  logic [1:0]  cbOnPin, coilVoltOk, coilOut, chainOut, inhibitLed, fireLed, cbOnLed;
  logic [1:0]  coilRedLed, coilFlash;
  logic        healthRelay, faultRelay, cbFailOut;
  logic [3:0]  sensorLed;
  logic [7:0]  mon;
  int          failures = 0, compares = 0, n, w;
  int          cnt [3];

  always #5 clock = ~clock;
  assign mon = {coilFlash[0], cbFailOut, healthRelay, faultRelay, chainOut, coilOut};
  // counted on the falling edge so the tally never races the outputs
  always @(negedge clock) begin
    if (coilOut[0]) cnt[0]++;
    if (chainOut[0]) cnt[1]++;
    if (cbFailOut) cnt[2]++;
  end

  afz_trip_zone #(.SECC(SECC), .CHAINC(CHAINC), .BLINKC(8), .COOLC(200)) uut (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sensorLevel(sensorLevel), .inhibitPin(inhibitPin),
    .firePin(firePin), .cbOnPin(cbOnPin), .resetPin(resetPin),
    .coilVoltOk(coilVoltOk), .errIn(errIn), .healthRelay(healthRelay),
    .faultRelay(faultRelay), .cbFailOut(cbFailOut), .coilOut(coilOut),
    .chainOut(chainOut), .inhibitLed(inhibitLed), .fireLed(fireLed),
    .cbOnLed(cbOnLed), .coilRedLed(coilRedLed), .coilFlash(coilFlash),
    .sensorLed(sensorLed)
  );
  afz_breaker_model #(.NZ(2), .OPENC(5)) breaker (
    .clock(clock), .coilOut(coilOut), .uvMode(uvMode), .stuck(stuck),
    .reclose(reclose), .supply(supply), .cbOnPin(cbOnPin), .coilVoltOk(coilVoltOk)
  );

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wait_bit(input int i, input logic v, input int lim, output int c);
    c = 0;
    #1;
    while (mon[i] !== v) begin
      @(posedge clock);
      #1;
      c++;
      if (c > lim) begin
        failures++;
        $display("CHECK FAILED t=%0t wait on output %0d ran out", $time, i);
        finish_test();
      end
    end
    @(posedge clock);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    // taken at the edge that closes the data cycle, before it returns to zero
    @(posedge clock);
    d = rdata;
  endtask
  task automatic pulse_reset();
    resetPin <= 1'b0;
    step(5);
    resetPin <= 1'b1;
    step(4);
  endtask
  task automatic fire0();
    cnt = '{0, 0, 0};
    reclose <= 2'h3;
    firePin[0] <= 1'b0;
    step(1);
    reclose <= 2'h0;
  endtask

  initial begin
    step(3);
    srst <= 1'b0;
    step(4);
    check(healthRelay, 1);
    check(faultRelay, 0);
    rd_reg(A_THRESH, rv);
    check(rv, 32'h0000_0064);
    rd_reg(A_MAP, rv);
    check(rv, 32'h0000_00A5);
    rd_reg(8'h40, rv);
    check(rv, 32'h0000_0000);
    wr_reg(A_THRESH, 32'h0000_00FF);
    rd_reg(A_THRESH, rv);
    check(rv, 32'h0000_00FA);
    sensorLevel <= 32'h0000_C800;
    step(8);
    check(sensorLed, 4'h0);
    sensorLevel <= '0;
    wr_reg(A_THRESH, 32'h0000_0064);
    wr_reg(A_PULSE, PULSE);
    wr_reg(A_CBFTO, CBFT);
    // first trip: full pulse, chain pulse, fault flag, no breaker failure
    fire0();
    wait_bit(0, 1'b1, 10, n);
    check(n <= 6, 1);
    check(fireLed[0], 1);
    step(PULSE + 40);
    check(cnt[0], PULSE);
    check(cnt[1], CHAINC);
    check(cnt[2], 0);
    check(faultRelay, 1);
    check(coilRedLed[0], 1);
    check(cbOnLed[0], 0);
    rd_reg(A_STAT, rv);
    check(rv, (32'h1 << ST_HEALTH) | (32'h1 << ST_FAULT) | (32'h1 << ST_COIL));
    // repeat trip before reset
    firePin[0] <= 1'b1;
    step(6);
    fire0();
    wait_bit(4, 1'b0, 10, n);
    wait_bit(4, 1'b1, SECC + 5, w);
    // the trailing edge of the first wait hides one cycle of the drop
    check(w + 1, SECC);
    step(PULSE + 30);
    check(cnt[0] > 0 && cnt[0] < PULSE, 1);
    firePin[0] <= 1'b1;
    pulse_reset();
    check(faultRelay, 0);
    check(coilRedLed[0], 0);
    check(fireLed[0], 0);
    // errors: reset leaves them, extra error pulses the health relay
    errIn <= 2'h1;
    step(3);
    check(healthRelay, 0);
    pulse_reset();
    check(healthRelay, 0);
    errIn <= 2'h3;
    wait_bit(5, 1'b1, 5, n);
    wait_bit(5, 1'b0, SECC + 5, w);
    check(w + 1, SECC);
    errIn <= 2'h0;
    step(3);
    check(healthRelay, 1);
    // suppressed zone 1 with light and remote fire
    inhibitPin[1] <= 1'b0;
    // light is not synchronised, so the suppress must settle first
    step(3);
    sensorLevel <= 32'hC800_0000;
    firePin[1] <= 1'b0;
    step(12);
    check(sensorLed[3], 1);
    check(coilOut[1], 0);
    check(faultRelay, 0);
    check(inhibitLed[1], 1);
    sensorLevel <= '0;
    firePin[1] <= 1'b1;
    step(4);
    inhibitPin[1] <= 1'b1;
    pulse_reset();
    // stuck breaker on zone 1
    stuck[1] <= 1'b1;
    cnt = '{0, 0, 0};
    sensorLevel <= 32'hC800_0000;
    wait_bit(1, 1'b1, 10, n);
    step(CBFT + 30);
    check(cnt[2], CHAINC);
    check(cbOnLed[1], 1);
    sensorLevel <= '0;
    stuck[1] <= 1'b0;
    pulse_reset();
    // reset held low clears once the trip is over
    resetPin <= 1'b0;
    fire0();
    wait_bit(4, 1'b1, 10, n);
    wait_bit(4, 1'b0, CBFT + 40, n);
    check(faultRelay, 0);
    firePin[0] <= 1'b1;
    resetPin <= 1'b1;
    step(4);
    // undervoltage mode idles high
    wr_reg(A_CTRL, 32'h0000_0002);
    uvMode <= 2'h2;
    step(3);
    check(coilOut[1], 1);
    firePin[1] <= 1'b0;
    wait_bit(1, 1'b0, 10, n);
    check(n <= 6, 1);
    wait_bit(1, 1'b1, PULSE + 5, w);
    firePin[1] <= 1'b1;
    rd_reg(A_CTRL, rv);
    check(rv, 32'h0000_0002);
    wr_reg(A_CTRL, 32'h0000_0000);
    uvMode <= 2'h0;
    // missing coil supply
    supply[0] <= 1'b0;
    step(4);
    check(healthRelay, 0);
    wait_bit(7, 1'b1, 20, n);
    wait_bit(7, 1'b0, 20, n);
    supply[0] <= 1'b1;
    step(4);
    check(healthRelay, 1);
    // sensor 0 remapped to zone 1 only
    wr_reg(A_MAP, 32'h0000_0002);
    cnt = '{0, 0, 0};
    sensorLevel <= 32'h0000_00C8;
    wait_bit(1, 1'b1, 10, n);
    check(cnt[0], 0);
    sensorLevel <= '0;
    wr_reg(A_MAP, 32'h0000_00A5);
    step(CBFT + 20);
    pulse_reset();
    // inverted feedback: an opened breaker now reads as still closed
    wr_reg(A_CTRL, 32'h0000_0100);
    fire0();
    step(CBFT + 30);
    check(cnt[2], CHAINC);
    firePin[0] <= 1'b1;
    wr_reg(A_CMD, 32'h0000_0001);
    step(3);
    check(faultRelay, 0);
    finish_test();
  end
endmodule
